//--- verilog/pllhd_top.sv
// Purpose: loop-one lock detect, holdover control and output source muxes
// Assumes: classic wishbone slave, 32-bit data, one clock at 125 MHz
// Notes: a too-small lock count lets holdover chatter; software sizes it
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module pllhd_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pllhd_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // phase detector and reference
    input wire logic pd_strobe_i,
    input wire logic [pllhd_pkg::PHASE_W-1:0] phase_err_i,
    input wire logic ref_valid_i,
    input wire logic [pllhd_pkg::DAC_W-1:0] tune_track_i,
    // loop control outputs
    output logic lock_indicator_o,
    output logic holdover_o,
    output logic relock_pulse_o,
    output logic tune_force_o,
    output logic [pllhd_pkg::DAC_W-1:0] tune_dac_o,
    // output source muxes
    output logic out3_osc_sel_o,
    output logic out4_osc_sel_o
);
    import pllhd_pkg::*;

    // true when a source code names the oscillator input
    function automatic logic picks_osc(input logic [SRC_W-1:0] code);
        picks_osc = (code == SRC_OSC_INPUT);
    endfunction : picks_osc

    // true while the state machine holds the loop in holdover
    function automatic logic in_hold(input pllhd_state_type st);
        in_hold = (st == ST_HOLDOVER);
    endfunction : in_hold

    // true when the holdover select field enables holdover
    function automatic logic hold_on(input logic [1:0] sel);
        hold_on = (sel == HOLD_SEL_ENABLE);
    endfunction : hold_on

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // software registers
    logic [1:0] hold_sel_ff;
    logic [1:0] nxt_hold_sel;
    logic track_en_ff;
    logic nxt_track_en;
    logic man_sel_ff;
    logic nxt_man_sel;
    logic inhibit_ff;
    logic nxt_inhibit;
    logic [CNT_W-1:0] lock_cnt_ff;
    logic [CNT_W-1:0] nxt_lock_cnt;
    logic [PHASE_W-1:0] window_ff;
    logic [PHASE_W-1:0] nxt_window;
    logic [DAC_W-1:0] manual_dac_value_ff;
    logic [DAC_W-1:0] nxt_manual_dac_value;
    logic [SRC_W-1:0] src3_ff;
    logic [SRC_W-1:0] nxt_src3;
    logic [SRC_W-1:0] src4_ff;
    logic [SRC_W-1:0] nxt_src4;
    // bus answer
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] rdat_ff;
    logic [31:0] nxt_rdat;
    // loop state
    pllhd_state_type state_ff;
    pllhd_state_type nxt_state;
    logic lock_q;
    logic lock_prev_ff;
    logic nxt_lock_prev;
    logic [DAC_W-1:0] track_ff;
    logic [DAC_W-1:0] nxt_track;
    logic relock_ff;
    logic nxt_relock;
    logic [DAC_W-1:0] dac_ff;
    logic [DAC_W-1:0] nxt_dac;
    logic force_ff;
    logic nxt_force;
    logic sel3_ff;
    logic nxt_sel3;
    logic sel4_ff;
    logic nxt_sel4;
    // decode helpers
    logic access;
    logic [31:0] ctrl_word;
    logic [31:0] src_word;
    logic [31:0] stat_word;
    logic [31:0] rd_word;
    logic [31:0] wr_word;

    // qualification counter and lock flag
    pllhd_qualify u_qualify (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pd_strobe_i(pd_strobe_i),
        .phase_err_i(phase_err_i),
        .window_i(window_ff),
        .threshold_i(lock_cnt_ff),
        .restart_i(relock_ff),
        .lock_o(lock_q)
    );

    // register images for read-back
    always_comb begin
        ctrl_word = '0;
        ctrl_word[CTRL_HOLD_SEL_LSB +: 2] = hold_sel_ff;
        ctrl_word[CTRL_TRACK_EN_BIT] = track_en_ff;
        ctrl_word[CTRL_MAN_SEL_BIT] = man_sel_ff;
        ctrl_word[CTRL_INHIBIT_BIT] = inhibit_ff;
        src_word = '0;
        src_word[SRC_OUT3_LSB +: SRC_W] = src3_ff;
        src_word[SRC_OUT4_LSB +: SRC_W] = src4_ff;
        // status follows live state, no shadow copy
        stat_word = '0;
        stat_word[STAT_LOCK_BIT] = lock_q;
        stat_word[STAT_HOLD_BIT] = in_hold(state_ff);
        stat_word[STAT_REF_BIT] = ref_valid_i;
        stat_word[STAT_TRACK_LSB +: DAC_W] = track_ff;
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        unique case (wb_adr_i)
            REG_CTRL: rd_word = ctrl_word;
            REG_LOCK_CNT: rd_word = {16'h0000, lock_cnt_ff};
            REG_WINDOW: rd_word = {16'h0000, window_ff};
            REG_MANUAL_DAC_VALUE: rd_word = {22'h000000, manual_dac_value_ff};
            REG_SRC_SEL: rd_word = src_word;
            REG_STATUS: rd_word = stat_word;
            default: rd_word = '0;
        endcase
    end

    // bus slave: one wait state, ack for one cycle
    always_comb begin
        access = wb_cyc_i && wb_stb_i && !ack_ff;
        wr_word = merge(rd_word, wb_dat_i, wb_sel_i);
        nxt_ack = access;
        // zero outside ack keeps stale data off the bus
        nxt_rdat = access ? rd_word : '0;
        nxt_hold_sel = hold_sel_ff;
        nxt_track_en = track_en_ff;
        nxt_man_sel = man_sel_ff;
        nxt_inhibit = inhibit_ff;
        nxt_lock_cnt = lock_cnt_ff;
        nxt_window = window_ff;
        nxt_manual_dac_value = manual_dac_value_ff;
        nxt_src3 = src3_ff;
        nxt_src4 = src4_ff;
        if (access && wb_we_i) begin
            unique case (wb_adr_i)
                REG_CTRL: begin
                    nxt_hold_sel = wr_word[CTRL_HOLD_SEL_LSB +: 2];
                    nxt_track_en = wr_word[CTRL_TRACK_EN_BIT];
                    nxt_man_sel = wr_word[CTRL_MAN_SEL_BIT];
                    nxt_inhibit = wr_word[CTRL_INHIBIT_BIT];
                end
                REG_LOCK_CNT: nxt_lock_cnt = wr_word[CNT_W-1:0];
                REG_WINDOW: nxt_window = wr_word[PHASE_W-1:0];
                REG_MANUAL_DAC_VALUE: nxt_manual_dac_value = wr_word[DAC_W-1:0];
                REG_SRC_SEL: begin
                    nxt_src3 = wr_word[SRC_OUT3_LSB +: SRC_W];
                    nxt_src4 = wr_word[SRC_OUT4_LSB +: SRC_W];
                end
                default: ; // status and holes ignore writes
            endcase
        end
    end

    // holdover state machine
    always_comb begin
        nxt_state = state_ff;
        nxt_relock = 1'b0;
        nxt_lock_prev = lock_q;
        unique case (state_ff)
            ST_ACQUIRE: begin
                if (lock_q) begin
                    nxt_state = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                if (!lock_q && lock_prev_ff) begin
                    // a small lock count lets this edge chatter
                    if (hold_on(hold_sel_ff) // R07
                        && !inhibit_ff) begin
                        nxt_state = ST_HOLDOVER; // R03
                    end else begin
                        nxt_state = ST_ACQUIRE;
                    end
                end
            end
            ST_HOLDOVER: begin
                // leaving also clears the qualifier for a fresh count
                if (ref_valid_i) begin
                    nxt_state = ST_ACQUIRE; // R04
                    nxt_relock = 1'b1; // R04
                end else if (!hold_on(hold_sel_ff)) begin
                    nxt_state = ST_ACQUIRE; // R07
                    nxt_relock = 1'b1;
                end
            end
        endcase
    end

    // tuning value tracking and holdover drive
    always_comb begin
        nxt_track = track_ff;
        // the tracked word freezes once the loop leaves lock
        if (track_en_ff && state_ff == ST_LOCKED) begin
            nxt_track = tune_track_i;
        end
        // force rises with the state, not one edge behind it
        nxt_force = in_hold(nxt_state);
        // without tracking the tracked word is never used
        if (man_sel_ff || !track_en_ff) begin // R08
            nxt_dac = manual_dac_value_ff; // R09 R10
        end else begin
            nxt_dac = track_ff;
        end
        // mux decode registered so the selects never glitch
        nxt_sel3 = picks_osc(src3_ff); // R11
        nxt_sel4 = picks_osc(src4_ff); // R11
    end

    // register stage for all state
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_sel_ff <= HOLD_SEL_RST;
            track_en_ff <= 1'b0;
            man_sel_ff <= 1'b0;
            inhibit_ff <= 1'b0;
            lock_cnt_ff <= LOCK_CNT_RST;
            window_ff <= WINDOW_RST;
            manual_dac_value_ff <= MANUAL_DAC_VALUE_RST;
            src3_ff <= SRC_RST;
            src4_ff <= SRC_RST;
            ack_ff <= 1'b0;
            rdat_ff <= '0;
            state_ff <= ST_ACQUIRE;
            lock_prev_ff <= 1'b0;
            track_ff <= MANUAL_DAC_VALUE_RST;
            relock_ff <= 1'b0;
            dac_ff <= MANUAL_DAC_VALUE_RST;
            force_ff <= 1'b0;
            sel3_ff <= 1'b0;
            sel4_ff <= 1'b0;
        end else begin
            hold_sel_ff <= nxt_hold_sel;
            track_en_ff <= nxt_track_en;
            man_sel_ff <= nxt_man_sel;
            inhibit_ff <= nxt_inhibit;
            lock_cnt_ff <= nxt_lock_cnt;
            window_ff <= nxt_window;
            manual_dac_value_ff <= nxt_manual_dac_value;
            src3_ff <= nxt_src3;
            src4_ff <= nxt_src4;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
            state_ff <= nxt_state;
            lock_prev_ff <= nxt_lock_prev;
            track_ff <= nxt_track;
            relock_ff <= nxt_relock;
            dac_ff <= nxt_dac;
            force_ff <= nxt_force;
            sel3_ff <= nxt_sel3;
            sel4_ff <= nxt_sel4;
        end
    end

    // outputs from flip-flops, holdover_o decoded from state_ff
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign lock_indicator_o = lock_q;
    assign holdover_o = in_hold(state_ff);
    assign relock_pulse_o = relock_ff;
    assign tune_force_o = force_ff;
    assign tune_dac_o = dac_ff;
    assign out3_osc_sel_o = sel3_ff;
    assign out4_osc_sel_o = sel4_ff;
endmodule : pllhd_top

//--- verilog/pllhd_pkg.sv
// Purpose: shared constants for the loop-one lock detect / holdover block
// Assumes: one 125 MHz clock, classic wishbone register access
// Notes: every offset and field, and the multi-bit reset values, live here
// Behaviour
// R01: lock indicator rises after the phase error stays in window for the lock count of detector cycles.
// R02: lock indicator drops whenever the phase error leaves the window, even after lock.
// R03: with the lock-loss inhibit bit at 0, a falling lock indicator enters holdover.
// R04: in holdover a valid reference ends holdover and restarts locking.
// R05: lock time is the lock count times the detector period.
// R06: software must program a lock count large enough to avoid holdover chatter.
// R07: holdover select value 2 enables holdover.
// R08: tracking enable 0 stops tracking, so holdover never uses a tracked value.
// R09: manual dac select 1 drives the holdover tuning value from the manual dac value.
// R10: manual dac value 512 gives about half the supply as tuning voltage.
// R11: outputs 3 and 4 each have a source mux where code 0x01 picks the oscillator input.
// R12: an out-of-window detector cycle clears the lock qualification counter.
package pllhd_pkg;
    // widths
    localparam int unsigned PHASE_W = 16;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned DAC_W = 10;
    localparam int unsigned SRC_W = 2;
    localparam int unsigned ADR_W = 8;

    // register byte offsets
    localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] REG_LOCK_CNT = 8'h04;
    localparam logic [ADR_W-1:0] REG_WINDOW = 8'h08;
    localparam logic [ADR_W-1:0] REG_MANUAL_DAC_VALUE = 8'h0c;
    localparam logic [ADR_W-1:0] REG_SRC_SEL = 8'h10;
    localparam logic [ADR_W-1:0] REG_STATUS = 8'h14;

    // control and source select field positions
    localparam int unsigned CTRL_HOLD_SEL_LSB = 0;
    localparam int unsigned CTRL_TRACK_EN_BIT = 2;
    localparam int unsigned CTRL_MAN_SEL_BIT = 3;
    localparam int unsigned CTRL_INHIBIT_BIT = 4;
    localparam int unsigned SRC_OUT3_LSB = 0;
    localparam int unsigned SRC_OUT4_LSB = 8;

    // status field positions
    localparam int unsigned STAT_LOCK_BIT = 0;
    localparam int unsigned STAT_HOLD_BIT = 1;
    localparam int unsigned STAT_REF_BIT = 2;
    localparam int unsigned STAT_TRACK_LSB = 16;

    // field encodings
    localparam logic [1:0] HOLD_SEL_ENABLE = 2'h2;
    localparam logic [SRC_W-1:0] SRC_OSC_INPUT = 2'h1;

    // reset values
    localparam logic [1:0] HOLD_SEL_RST = 2'h0;
    localparam logic [CNT_W-1:0] LOCK_CNT_RST = 16'h2710;
    localparam logic [PHASE_W-1:0] WINDOW_RST = 16'h0010;
    localparam logic [DAC_W-1:0] MANUAL_DAC_VALUE_RST = 10'h200;
    localparam logic [SRC_W-1:0] SRC_RST = 2'h0;

    // holdover state machine, gray along acquire, locked, holdover
    typedef enum logic [1:0] {
        ST_ACQUIRE = 2'b00,
        ST_LOCKED = 2'b01,
        ST_HOLDOVER = 2'b11
    } pllhd_state_type;
endpackage : pllhd_pkg

//--- verilog/pllhd_qualify.sv
// Purpose: counts consecutive in-window detector cycles into a lock flag
// Assumes: pd_strobe_i is one clk_i cycle per phase-detector cycle
// Notes: counter saturates at the threshold, so it never wraps
`timescale 1ns/1ps
module pllhd_qualify (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // detector sample
    input wire logic pd_strobe_i,
    input wire logic [pllhd_pkg::PHASE_W-1:0] phase_err_i,
    // settings
    input wire logic [pllhd_pkg::PHASE_W-1:0] window_i,
    input wire logic [pllhd_pkg::CNT_W-1:0] threshold_i,
    input wire logic restart_i,
    // result
    output logic lock_o
);
    import pllhd_pkg::*;

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic lock_ff;
    logic nxt_lock;
    logic in_window;

    // window compare and qualification count
    always_comb begin
        in_window = (phase_err_i <= window_i);
        nxt_cnt = cnt_ff;
        nxt_lock = lock_ff;
        if (restart_i) begin
            nxt_cnt = '0;
            nxt_lock = 1'b0;
        end else if (pd_strobe_i) begin
            if (!in_window) begin
                nxt_cnt = '0; // R12
                nxt_lock = 1'b0; // R02
            end else if (cnt_ff < threshold_i) begin
                // lock time is threshold detector periods
                nxt_cnt = cnt_ff + 1'b1; // R05
                nxt_lock = ((cnt_ff + 1'b1) >= threshold_i); // R01
            end else begin
                nxt_lock = 1'b1; // R01
            end
        end
    end

    // register stage
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= '0;
            lock_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            lock_ff <= nxt_lock;
        end
    end

    assign lock_o = lock_ff;
endmodule : pllhd_qualify

//--- bench/pllhd_assertions.sv
// Purpose: port checks for the lock detect and holdover block
// Assumes: one clock, asynchronous active-low reset
// Notes: register contents are unseen here, only their effects
`timescale 1ns/1ps
module pllhd_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // detector and loop
    input wire logic pd_strobe_i,
    input wire logic lock_indicator_o,
    input wire logic holdover_o,
    input wire logic relock_pulse_o,
    input wire logic tune_force_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // bus answers: one cycle late, one cycle long
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    // lock only moves on a detector cycle or a relock
    a_lock_rise: assert property ($rose(lock_indicator_o) |->
        $past(pd_strobe_i)) else $error("lock rose without strobe");
    a_lock_fall: assert property ($fell(lock_indicator_o) |->
        $past(pd_strobe_i) || $past(relock_pulse_o))
        else $error("lock fell without cause");
    // holdover follows a falling lock one edge later
    a_hold_entry: assert property ($rose(holdover_o) |->
        $past(lock_indicator_o, 2) && !$past(lock_indicator_o))
        else $error("holdover without lock loss");
    a_force_hold: assert property (tune_force_o == holdover_o)
        else $error("force and holdover disagree");
    // exit gives one relock pulse, then the qualifier restarts
    a_exit_pulse: assert property ($fell(holdover_o) |->
        relock_pulse_o) else $error("exit without relock pulse");
    a_relock_clear: assert property (relock_pulse_o |=>
        !relock_pulse_o && !lock_indicator_o)
        else $error("relock did not restart locking");
endmodule : pllhd_assertions

//--- bench/pllhd_ref_model.sv
// Purpose: reference side: detector strobes, phase error, ref valid
// Assumes: the bench asks for counted bursts of detector cycles
// Notes: error bus inverts between strobes so stale data never matches
`timescale 1ns/1ps
module pllhd_ref_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // bench control
    input wire logic start_i,
    input wire logic [7:0] count_i,
    input wire logic [pllhd_pkg::PHASE_W-1:0] err_i,
    input wire logic slow_i,
    input wire logic ref_ok_i,
    output logic busy_o,
    // toward the block
    output logic pd_strobe_o,
    output logic [pllhd_pkg::PHASE_W-1:0] phase_err_o,
    output logic ref_valid_o,
    output logic [pllhd_pkg::DAC_W-1:0] tune_track_o
);
    import pllhd_pkg::*;
    logic [7:0] left_ff;
    logic tick_ff;
    logic fire;
    // slow mode strobes every other clock
    assign fire = (left_ff != 8'h0) && (!slow_i || tick_ff);
    assign busy_o = left_ff != 8'h0;
    // one strobe per detector cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {left_ff, tick_ff, pd_strobe_o, phase_err_o} <= '0;
            {ref_valid_o, tune_track_o} <= '0;
        end else begin
            tick_ff <= ~tick_ff;
            left_ff <= start_i ? count_i : left_ff - {7'h0, fire};
            pd_strobe_o <= fire;
            phase_err_o <= fire ? err_i : ~phase_err_o;
            ref_valid_o <= ref_ok_i;
            tune_track_o <= tune_track_o + 10'h7; // loop word drifts
        end
    end
endmodule : pllhd_ref_model

//--- bench/tb.sv
// Purpose: register, lock, holdover and source mux tests
// Assumes: detector bursts come from the reference model
// Notes: lock count is set small to keep runs short
`timescale 1ns/1ps
module tb;
    import pllhd_pkg::*;
    logic clk_i, rstn_i, cyc, stb, we, ack, start, slow, ref_ok, busy;
    logic strobe, refv, lock, hold, relock, frc, o3, o4;
    logic [3:0] sel;
    logic [7:0] adr, cnt;
    logic [15:0] err, perr;
    logic [31:0] wd, rd, q;
    logic [9:0] trk, dac, trk_last;
    int num_errors, checked, cyc_n, t;
    logic [7:0] regs [6] = '{REG_CTRL, REG_LOCK_CNT, REG_WINDOW,
        REG_MANUAL_DAC_VALUE, REG_SRC_SEL, 8'h20};
    logic [31:0] rstv [6] = '{32'h0, {16'h0, LOCK_CNT_RST},
        {16'h0, WINDOW_RST}, {22'h0, MANUAL_DAC_VALUE_RST}, 32'h0, 32'h0};

    pllhd_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
        .pd_strobe_i(strobe), .phase_err_i(perr), .ref_valid_i(refv),
        .tune_track_i(trk), .lock_indicator_o(lock), .holdover_o(hold),
        .relock_pulse_o(relock), .tune_force_o(frc), .tune_dac_o(dac),
        .out3_osc_sel_o(o3), .out4_osc_sel_o(o4));
    pllhd_ref_model i_ref (.clk_i(clk_i), .rstn_i(rstn_i),
        .start_i(start), .count_i(cnt), .err_i(err), .slow_i(slow),
        .ref_ok_i(ref_ok), .busy_o(busy), .pd_strobe_o(strobe),
        .phase_err_o(perr), .ref_valid_o(refv), .tune_track_o(trk));

    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            num_errors++;
            complete_run();
        end
    end

    // last loop word offered before holdover begins
    always @(posedge clk_i) begin
        if (hold !== 1'b1) begin
            trk_last <= trk;
        end
    end

    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // classic single cycle, held until ack is seen
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, wd} <= {2'b11, w, a, 4'hf, d};
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 20);
        q = rd;
        {cyc, stb} <= 2'b00;
        chk({31'h0, ack}, 32'h1);
    endtask : bus

    // n detector cycles with error e, lock indicator settled on return, holdover one edge later
    task automatic burst(input logic [7:0] n, input logic [15:0] e);
        @(posedge clk_i);
        {cnt, err, start} <= {n, e, 1'b1};
        @(posedge clk_i);
        start <= 1'b0;
        do @(posedge clk_i); while (busy === 1'b1);
        @(negedge clk_i);
    endtask : burst

    initial begin
        rstn_i = 1'b0;
        {cyc, stb, we, start, slow, ref_ok} = '0;
        {adr, sel, wd, cnt, err, num_errors, checked, cyc_n} = '0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(negedge clk_i);
        chk({26'h0, lock, hold, relock, frc, o3, o4}, 32'h0);
        chk({22'h0, dac}, 32'h200);
        foreach (regs[i]) begin
            bus(1'b0, regs[i], 32'h0);
            chk(q, rstv[i]);
        end
        $display("test reset done");
        // every code on both muxes
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, REG_SRC_SEL, {22'h0, 2'(3 - c), 6'h0, 2'(c)});
            @(negedge clk_i);
            chk({30'h0, o3, o4}, {30'h0, c == 1, c == 2});
        end
        $display("test mux done");
        bus(1'b1, REG_LOCK_CNT, 32'h3);
        bus(1'b1, REG_WINDOW, 32'h8);
        burst(8'd2, 16'h8);
        burst(8'd1, 16'h9);
        burst(8'd2, 16'h0);
        chk({31'h0, lock}, 32'h0);
        burst(8'd1, 16'h8);
        chk({31'h0, lock}, 32'h1);
        burst(8'd1, 16'h9);
        chk({31'h0, lock}, 32'h0);
        @(negedge clk_i);
        chk({31'h0, hold}, 32'h0);
        $display("test lock done");
        bus(1'b1, REG_CTRL, 32'ha);
        slow <= 1'b1;
        burst(8'd3, 16'h0);
        burst(8'd1, 16'h12c);
        chk({31'h0, lock}, 32'h0);
        @(negedge clk_i);
        chk({30'h0, hold, frc}, 32'h3);
        chk({22'h0, dac}, 32'h200);
        @(posedge clk_i);
        ref_ok <= 1'b1;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (hold === 1'b1 && t < 10);
        chk({31'h0, relock}, 32'h1);
        @(negedge clk_i);
        chk({30'h0, lock, relock}, 32'h0);
        burst(8'd3, 16'h0);
        chk({30'h0, lock, hold}, 32'h2);
        $display("test holdover done");
        @(posedge clk_i);
        ref_ok <= 1'b0;
        bus(1'b1, REG_CTRL, 32'h1a);
        burst(8'd3, 16'h0);
        burst(8'd1, 16'h12c);
        repeat (2) @(negedge clk_i);
        chk({30'h0, lock, hold}, 32'h0);
        $display("test inhibit done");
        bus(1'b1, REG_CTRL, 32'h2);
        bus(1'b1, REG_MANUAL_DAC_VALUE, 32'h0ab);
        burst(8'd3, 16'h0);
        burst(8'd1, 16'h12c);
        @(negedge clk_i);
        chk({21'h0, hold, dac}, 32'h4ab);
        bus(1'b1, REG_STATUS, 32'hffff_ffff);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q & 32'h7, 32'h2);
        $display("test tracking done");
        bus(1'b1, REG_CTRL, 32'h6);
        @(posedge clk_i);
        ref_ok <= 1'b1;
        burst(8'd3, 16'h0);
        chk({30'h0, lock, hold}, 32'h2);
        @(posedge clk_i);
        ref_ok <= 1'b0;
        burst(8'd1, 16'h12c);
        repeat (2) @(negedge clk_i);
        chk({21'h0, hold, dac}, {21'h0, 1'b1, trk_last});
        $display("test track on done");
        complete_run();
    end
endmodule : tb

bind pllhd_top pllhd_assertions i_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pd_strobe_i(pd_strobe_i),
    .lock_indicator_o(lock_indicator_o), .holdover_o(holdover_o),
    .relock_pulse_o(relock_pulse_o), .tune_force_o(tune_force_o));
